//--- hdl/lvrw_pkg.sv
package lvrw_pkg;
  // ----------------------------------------
  // Reset vector and reset-cause indices
  // ----------------------------------------
  localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hFFFF;
  localparam int CAUSE_WATCHDOG = 0;
  localparam int CAUSE_LOWVOLT = 1;
  localparam int CAUSE_PIN = 2;
  localparam int CAUSE_ILL_OPCODE = 3;
  localparam int CAUSE_ILL_ADDR = 4;
  localparam int NUM_CAUSES = 5;

  // ----------------------------------------
  // Reset source status layout (8 bits)
  // ----------------------------------------
  localparam int STAT_POR_BIT = 7;
  localparam int STAT_PIN_BIT = 6;
  localparam int STAT_WDOG_BIT = 5;
  localparam int STAT_ILLOP_BIT = 4;
  localparam int STAT_ILLADDR_BIT = 3;
  localparam int STAT_LOWVOLT_BIT = 1;
  localparam logic [7:0] STAT_RESET_VAL = 8'h82;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    LVRW_POR_HOLD = 3'h1,
    LVRW_LV_HOLD = 3'h2,
    LVRW_RUN = 3'h4
  } lvrw_state_e;
endpackage : lvrw_pkg

//--- hdl/lvrw_if.sv
// ----------------------------------------
// Detection gating results between modules
// ----------------------------------------
interface lvrw_if;
  logic detect_on;
  logic low_now;
  logic warn_now;
  logic deep_stop_block;
  modport gate (output detect_on, output low_now, output warn_now,
                output deep_stop_block);
  modport core (input detect_on, input low_now, input warn_now,
                input deep_stop_block);
endinterface : lvrw_if

//--- hdl/lvrw_gate.sv
module lvrw_gate (
  input wire logic lowvolt_detect_en, // Detection enable
  input wire logic lowvolt_stop_en, // Keep detection in stop
  input wire logic in_stop, // Any stop mode active
  input wire logic lowvolt_threshold_sel, // Trip point select
  input wire logic cmp_below_low, // Below low threshold
  input wire logic cmp_below_high, // Below high threshold
  input wire logic cmp_warn, // Below warning level
  lvrw_if.gate g // Gated results
);
  import lvrw_pkg::*;

  // Detector powered only when enabled and not stopped without stop_en
  assign g.detect_on = lowvolt_detect_en &
                       (~in_stop | lowvolt_stop_en);
  // Threshold chosen by select bit
  assign g.low_now = g.detect_on & (lowvolt_threshold_sel ?
                     cmp_below_high : cmp_below_low);
  assign g.warn_now = g.detect_on & cmp_warn;
  // Detection must survive stop, so deep stop is refused
  assign g.deep_stop_block = lowvolt_detect_en & lowvolt_stop_en;
endmodule : lvrw_gate

//--- hdl/lvrw_ctrl.sv
module lvrw_ctrl (
  input wire logic ref_clk, // Bus clock
  input wire logic rst, // Async power-on reset
  input wire logic por_detect, // Power-on detector active
  input wire logic cmp_below_low, // Supply below low threshold
  input wire logic cmp_below_high, // Supply below high threshold
  input wire logic cmp_warn, // Supply below warning level
  input wire logic lowvolt_detect_en, // Detection enable
  input wire logic lowvolt_stop_en, // Detection kept in stop
  input wire logic lowvolt_reset_en, // Reset on low voltage
  input wire logic lowvolt_threshold_sel, // Trip point select
  input wire logic lowvolt_warn_irq_en, // Warning interrupt enable
  input wire logic warn_flag_clr, // Software clear of warning flag
  input wire logic stop_req, // Core executes stop
  input wire logic deep_stop_req, // Stop is a deep stop request
  input wire logic stop_exit, // Wakeup leaves stop
  input wire logic wdog_rst, // Watchdog timeout
  input wire logic pin_rst, // External reset pin
  input wire logic ill_opcode_rst, // Illegal opcode
  input wire logic ill_addr_rst, // Illegal address
  output logic sys_reset, // System reset to core
  output logic [7:0] reset_source_status, // Reset cause flags
  output logic lowvolt_warn_flag, // Warning flag
  output logic lowvolt_warn_irq, // Warning interrupt request
  output logic deep_stop_mode, // In deep stop
  output logic shallow_stop_mode, // In shallow stop
  output logic [15:0] reset_vector_addr // Vector fetch address
);
  import lvrw_pkg::*;

  lvrw_if gi ();
  lvrw_state_e state;
  lvrw_state_e next_state;
  logic in_stop;
  logic [NUM_CAUSES-1:0] causes;
  logic other_rst;
  logic lv_trip;

  assign in_stop = deep_stop_mode | shallow_stop_mode;
  assign causes = {ill_addr_rst, ill_opcode_rst, pin_rst, 1'b0, wdog_rst};
  assign other_rst = |causes;
  assign lv_trip = lowvolt_reset_en & gi.low_now;

  lvrw_gate u_gate (
    .lowvolt_detect_en(lowvolt_detect_en),
    .lowvolt_stop_en(lowvolt_stop_en),
    .in_stop(in_stop),
    .lowvolt_threshold_sel(lowvolt_threshold_sel),
    .cmp_below_low(cmp_below_low),
    .cmp_below_high(cmp_below_high),
    .cmp_warn(cmp_warn),
    .g(gi)
  );

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  // Power-on hold uses the low comparator directly: enables are at reset
  always_comb begin
    next_state = state;
    if (por_detect) begin
      next_state = LVRW_POR_HOLD;
    end else begin
      case (state)
        LVRW_POR_HOLD: begin
          if (!cmp_below_low) next_state = LVRW_RUN;
        end
        LVRW_LV_HOLD: begin
          if (!gi.low_now) next_state = LVRW_RUN;
        end
        LVRW_RUN: begin
          if (lv_trip) next_state = LVRW_LV_HOLD;
        end
        default: next_state = LVRW_POR_HOLD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= LVRW_POR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // System reset while holding or for as long as another cause is asserted
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= (next_state != LVRW_RUN) | other_rst;
    end
  end

  // Every cause enters through the single highest-priority vector
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_vector_addr <= RESET_VEC_HI_ADDR;
    end else begin
      reset_vector_addr <= RESET_VEC_HI_ADDR;
    end
  end

  // ----------------------------------------
  // Reset source status
  // ----------------------------------------
  // Latest reset cause replaces the old record; low-voltage keeps POR bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_source_status <= STAT_RESET_VAL;
    end else if (por_detect) begin
      reset_source_status <= STAT_RESET_VAL;
    end else if (state == LVRW_RUN && lv_trip) begin
      reset_source_status[STAT_LOWVOLT_BIT] <= 1'b1;
      reset_source_status[STAT_PIN_BIT] <= 1'b0;
      reset_source_status[STAT_WDOG_BIT] <= 1'b0;
      reset_source_status[STAT_ILLOP_BIT] <= 1'b0;
      reset_source_status[STAT_ILLADDR_BIT] <= 1'b0;
    end else if (state == LVRW_RUN && other_rst) begin
      reset_source_status <= '0;
      reset_source_status[STAT_WDOG_BIT] <= causes[CAUSE_WATCHDOG];
      reset_source_status[STAT_PIN_BIT] <= causes[CAUSE_PIN];
      reset_source_status[STAT_ILLOP_BIT] <= causes[CAUSE_ILL_OPCODE];
      reset_source_status[STAT_ILLADDR_BIT] <= causes[CAUSE_ILL_ADDR];
    end
  end

  // ----------------------------------------
  // Warning flag and interrupt
  // ----------------------------------------
  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lowvolt_warn_flag <= 1'b0;
    end else if (sys_reset) begin
      lowvolt_warn_flag <= 1'b0;
    end else if (gi.warn_now && lowvolt_warn_irq_en) begin
      lowvolt_warn_flag <= 1'b1;
    end else if (warn_flag_clr) begin
      lowvolt_warn_flag <= 1'b0;
    end
  end

  // Request mirrors flag and enable, one cycle behind the flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lowvolt_warn_irq <= 1'b0;
    end else begin
      lowvolt_warn_irq <= lowvolt_warn_flag & lowvolt_warn_irq_en;
    end
  end

  // ----------------------------------------
  // Stop mode control
  // ----------------------------------------
  // Deep request falls back to shallow while detection must stay alive
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      deep_stop_mode <= 1'b0;
      shallow_stop_mode <= 1'b0;
    end else if (sys_reset || stop_exit) begin
      deep_stop_mode <= 1'b0;
      shallow_stop_mode <= 1'b0;
    end else if (stop_req && !in_stop) begin
      deep_stop_mode <= deep_stop_req & ~gi.deep_stop_block;
      shallow_stop_mode <= ~deep_stop_req | gi.deep_stop_block;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Judged at entry only: enables may change while already stopped
  property p_deep_refused;
    @(posedge ref_clk) disable iff (rst)
    (stop_req && deep_stop_req && !in_stop && !sys_reset && !stop_exit &&
     lowvolt_detect_en && lowvolt_stop_en) |=>
      !deep_stop_mode && shallow_stop_mode;
  endproperty
  a_deep_refused: assert property (p_deep_refused)
    else $error("deep stop entered with detection kept in stop");

  property p_deep_enter;
    @(posedge ref_clk) disable iff (rst)
    (stop_req && deep_stop_req && !in_stop && !sys_reset && !stop_exit &&
     !(lowvolt_detect_en && lowvolt_stop_en)) |=>
      deep_stop_mode && !shallow_stop_mode;
  endproperty
  a_deep_enter: assert property (p_deep_enter)
    else $error("deep stop refused without need");

  property p_por_reset;
    @(posedge ref_clk) disable iff (rst)
    por_detect |=> sys_reset;
  endproperty
  a_por_reset: assert property (p_por_reset)
    else $error("power-on event did not reset");

  property p_por_hold;
    @(posedge ref_clk) disable iff (rst)
    (state == LVRW_POR_HOLD && cmp_below_low) |=> sys_reset;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("reset released below low threshold");

  property p_por_flags;
    @(posedge ref_clk) disable iff (rst)
    por_detect |=> reset_source_status[STAT_POR_BIT] &&
                   reset_source_status[STAT_LOWVOLT_BIT];
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("power-on flags not set");

  property p_lv_reset;
    @(posedge ref_clk) disable iff (rst)
    (state == LVRW_RUN && lv_trip && !por_detect) |=>
      sys_reset && reset_source_status[STAT_LOWVOLT_BIT] ##1
      (state == LVRW_LV_HOLD || state == LVRW_POR_HOLD || !sys_reset);
  endproperty
  a_lv_reset: assert property (p_lv_reset)
    else $error("low-voltage reset missing");

  property p_lv_release;
    @(posedge ref_clk) disable iff (rst)
    (state == LVRW_LV_HOLD && !gi.low_now && !por_detect && !other_rst)
      |=> !sys_reset;
  endproperty
  a_lv_release: assert property (p_lv_release)
    else $error("reset not released above threshold");

  // Checked at the reset output, not at the gate term it is built from
  property p_detect_off;
    @(posedge ref_clk) disable iff (rst)
    (state == LVRW_RUN && !por_detect && !other_rst &&
     (!lowvolt_detect_en || (in_stop && !lowvolt_stop_en))) |=> !sys_reset;
  endproperty
  a_detect_off: assert property (p_detect_off)
    else $error("detection active while disabled");

  property p_warn_set;
    @(posedge ref_clk) disable iff (rst)
    (gi.warn_now && lowvolt_warn_irq_en && !sys_reset) |=>
      lowvolt_warn_flag ##1 lowvolt_warn_irq || !lowvolt_warn_irq_en;
  endproperty
  a_warn_set: assert property (p_warn_set)
    else $error("warning flag or request missing");

  property p_irq_hold;
    @(posedge ref_clk) disable iff (rst)
    (lowvolt_warn_flag && lowvolt_warn_irq_en) |=> lowvolt_warn_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("warning request dropped while flag set");

  property p_irq_drop;
    @(posedge ref_clk) disable iff (rst)
    !lowvolt_warn_flag |=> !lowvolt_warn_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("warning request without flag");

  // A clear only loses when a new warning sets the flag again
  property p_flag_clear;
    @(posedge ref_clk) disable iff (rst)
    (warn_flag_clr && !(gi.warn_now && lowvolt_warn_irq_en)) |=>
      !lowvolt_warn_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("warning flag survived its clear");

  property p_other_cause;
    @(posedge ref_clk) disable iff (rst)
    (state == LVRW_RUN && other_rst && !lv_trip && !por_detect) |=>
      sys_reset && !reset_source_status[STAT_POR_BIT] &&
      !reset_source_status[STAT_LOWVOLT_BIT];
  endproperty
  a_other_cause: assert property (p_other_cause)
    else $error("other reset cause not recorded");

  property p_vector;
    @(posedge ref_clk) disable iff (rst)
    $rose(sys_reset) |=> reset_vector_addr == RESET_VEC_HI_ADDR;
  endproperty
  a_vector: assert property (p_vector)
    else $error("reset vector address wrong");

  c_lv_reset: cover property (@(posedge ref_clk) disable iff (rst)
    state == LVRW_RUN ##1 state == LVRW_LV_HOLD ##[1:20] state == LVRW_RUN);
  c_warn_irq: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(lowvolt_warn_irq));
  c_shallow: cover property (@(posedge ref_clk) disable iff (rst)
    shallow_stop_mode && deep_stop_req);
  c_other_cause: cover property (@(posedge ref_clk) disable iff (rst)
    state == LVRW_RUN && other_rst);
endmodule : lvrw_ctrl

//--- tb/lvrw_core_model.sv
module lvrw_core_model (
  input wire logic ref_clk, // Bus clock
  input wire logic rst, // Power-on reset
  input wire logic sys_reset, // Reset from block
  input wire logic lowvolt_warn_irq, // Warning request
  input wire logic [3:0] svc_delay, // Service latency
  output logic warn_flag_clr // Flag clear write
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Service routine clears the flag before it returns; a slow
  // handler waits svc_delay cycles with the request seen before the clear write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      warn_flag_clr <= 1'b0;
    end else begin
      warn_flag_clr <= 1'b0;
      if (sys_reset || !lowvolt_warn_irq || warn_flag_clr) begin
        cnt <= 0;
      end else if (cnt >= svc_delay) begin
        warn_flag_clr <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : lvrw_core_model

//--- tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lvrw_pkg::*;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic ref_clk = 0, rst = 1, por_detect = 0, cmp_warn = 0;
  logic cmp_below_low = 1, cmp_below_high = 1;
  logic lowvolt_detect_en = 1, lowvolt_stop_en = 0, lowvolt_reset_en = 1;
  logic lowvolt_threshold_sel = 0, lowvolt_warn_irq_en = 0, warn_flag_clr;
  logic stop_req = 0, deep_stop_req = 0, stop_exit = 0;
  logic wdog_rst = 0, pin_rst = 0, ill_opcode_rst = 0, ill_addr_rst = 0;
  logic sys_reset, lowvolt_warn_flag, lowvolt_warn_irq;
  logic deep_stop_mode, shallow_stop_mode;
  logic [7:0] reset_source_status;
  logic [15:0] reset_vector_addr;
  logic [3:0] svc_delay = 4'h0;
  logic [3:0] obs;
  logic [31:0] rnd = 32'h27FF;
  int n_errors = 0, samples_checked = 0;
  int cause_bit[4] = '{STAT_WDOG_BIT, STAT_PIN_BIT, STAT_ILLOP_BIT,
                       STAT_ILLADDR_BIT};

  assign obs = {shallow_stop_mode, lowvolt_warn_irq, lowvolt_warn_flag,
                sys_reset};

  lvrw_ctrl lvrw_ctrl_i (.ref_clk, .rst, .por_detect, .cmp_below_low,
    .cmp_below_high, .cmp_warn, .lowvolt_detect_en, .lowvolt_stop_en,
    .lowvolt_reset_en, .lowvolt_threshold_sel, .lowvolt_warn_irq_en,
    .warn_flag_clr, .stop_req, .deep_stop_req, .stop_exit, .wdog_rst,
    .pin_rst, .ill_opcode_rst, .ill_addr_rst, .sys_reset,
    .reset_source_status, .lowvolt_warn_flag, .lowvolt_warn_irq,
    .deep_stop_mode, .shallow_stop_mode, .reset_vector_addr);

  lvrw_core_model lvrw_core_model_i (.ref_clk, .rst, .sys_reset,
    .lowvolt_warn_irq, .svc_delay, .warn_flag_clr);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Comparator that the select bit routes to the trip
  function automatic logic exp_trip(input logic sel, lo, hi);
    return sel ? hi : lo;
  endfunction : exp_trip

  // Deep stop only when detection need not stay alive
  function automatic logic exp_deep(input logic deep, de, se);
    return deep && !(de && se);
  endfunction : exp_deep

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait, so a stuck output cannot hang the run
  task automatic wt(input int k, input logic v, input int n);
    for (int i = 0; i < n && obs[k] !== v; i++) @(posedge ref_clk) #1;
    chk(obs[k], v);
  endtask : wt

  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (4000) @(posedge ref_clk);
    n_errors++;
    test_done;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    chk(sys_reset, 1'b1);
    chk(reset_source_status, STAT_RESET_VAL);
    chk(reset_vector_addr, RESET_VEC_HI_ADDR);
    rnd = lfsr(rnd);
    @(posedge ref_clk);
    rst <= 1'b0;
    svc_delay <= {1'b0, rnd[2:0]};
    repeat (6) @(posedge ref_clk);
    #1;
    chk(sys_reset, 1'b1);
    @(posedge ref_clk);
    {cmp_below_low, cmp_below_high} <= 2'b00;
    wt(0, 1'b0, 6);
    chk(reset_source_status[STAT_LOWVOLT_BIT], 1'b1);
    // Supply between the two thresholds, trip point at random
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      lowvolt_threshold_sel <= rnd[0];
      cmp_below_high <= 1'b1;
      if (exp_trip(rnd[0], 1'b0, 1'b1)) begin
        wt(0, 1'b1, 4);
        chk(reset_source_status[STAT_LOWVOLT_BIT], 1'b1);
        repeat (rnd[3:1]) @(posedge ref_clk);
        #1;
        chk(sys_reset, 1'b1);
        @(posedge ref_clk);
        cmp_below_high <= 1'b0;
        wt(0, 1'b0, 4);
      end else begin
        repeat (4) @(posedge ref_clk);
        #1;
        chk(sys_reset, 1'b0);
        @(posedge ref_clk);
        cmp_below_high <= 1'b0;
      end
    end
    @(posedge ref_clk);
    lowvolt_detect_en <= 1'b0;
    {cmp_below_low, cmp_below_high} <= 2'b11;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(sys_reset, 1'b0);
    @(posedge ref_clk);
    {cmp_below_low, cmp_below_high} <= 2'b00;
    lowvolt_detect_en <= 1'b1;
    cmp_warn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(lowvolt_warn_flag, 1'b0);
    @(posedge ref_clk);
    lowvolt_warn_irq_en <= 1'b1;
    wt(1, 1'b1, 4);
    wt(2, 1'b1, 4);
    @(posedge ref_clk);
    cmp_warn <= 1'b0;
    wt(2, 1'b0, 24);
    // Deep stop asked for, with and without detection kept alive
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      lowvolt_stop_en <= k[0];
      stop_req <= 1'b1;
      deep_stop_req <= 1'b1;
      @(posedge ref_clk);
      stop_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(deep_stop_mode, exp_deep(1'b1, 1'b1, k[0]));
      chk(shallow_stop_mode, !exp_deep(1'b1, 1'b1, k[0]));
      @(posedge ref_clk);
      // Supply below both thresholds, whichever trip point the select left
      {cmp_below_low, cmp_below_high} <= 2'b11;
      repeat (3) @(posedge ref_clk);
      #1;
      chk(sys_reset, k[0]);
      @(posedge ref_clk);
      {cmp_below_low, cmp_below_high} <= 2'b00;
      stop_exit <= 1'b1;
      @(posedge ref_clk);
      stop_exit <= 1'b0;
      wt(0, 1'b0, 6);
    end
    // Every other cause enters through the same vector
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {wdog_rst, pin_rst, ill_opcode_rst, ill_addr_rst} <= 4'h8 >> i;
      @(posedge ref_clk);
      {wdog_rst, pin_rst, ill_opcode_rst, ill_addr_rst} <= 4'h0;
      #1;
      wt(0, 1'b1, 3);
      wt(0, 1'b0, 6);
      chk(reset_source_status, 8'(1 << cause_bit[i]));
      chk(reset_vector_addr, RESET_VEC_HI_ADDR);
    end
    @(posedge ref_clk);
    por_detect <= 1'b1;
    @(posedge ref_clk);
    por_detect <= 1'b0;
    #1;
    wt(0, 1'b1, 3);
    wt(0, 1'b0, 6);
    chk(reset_source_status, STAT_RESET_VAL);
    test_done;
  end
endmodule : tb_top
